// file: logic/srap_pkg.sv
package srap_pkg;
  localparam logic [1:0] MODE_SPI = 2'h0;
  localparam logic [1:0] MODE_I2C = 2'h1;
  localparam logic [1:0] MODE_MIIM = 2'h2;
  localparam int SPI_CA_BITS = 27;
  localparam int SPI_TA_BITS = 5;
  localparam int SPI_DATA_BITS = 8;
  localparam logic [5:0] SPI_CA_LAST = 6'(SPI_CA_BITS - 1);
  localparam logic [5:0] SPI_DATA_FIRST = 6'(SPI_CA_BITS + SPI_TA_BITS);
  localparam logic [5:0] SPI_DATA_LAST =
    6'(SPI_CA_BITS + SPI_TA_BITS + SPI_DATA_BITS - 1);
  localparam logic [2:0] SPI_CMD_READ = 3'h3;
  localparam logic [2:0] SPI_CMD_WRITE = 3'h2;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h5F;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  localparam int SYS_PERIOD_NS = 100;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
endpackage

// file: logic/srap_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface srap_link_if;
  logic serial_clk;
  logic serial_select_low;
  logic host_in_o;
  logic host_in_oe_n;
  logic dev_in_o;
  logic dev_in_oe_n;
  logic dev_out_o;
  logic dev_out_oe_n;
  logic serial_in_line;
  logic serial_out_line;
  // shared input/data wire: pulled up, either end may pull it low
  assign serial_in_line = (host_in_oe_n | host_in_o) &
                          (dev_in_oe_n | dev_in_o);
  assign serial_out_line = dev_out_oe_n | dev_out_o;
  modport device(input serial_clk, input serial_select_low,
                 input serial_in_line, output dev_in_o,
                 output dev_in_oe_n, output dev_out_o,
                 output dev_out_oe_n);
  modport host(output serial_clk, output serial_select_low,
               output host_in_o, output host_in_oe_n,
               input serial_in_line, input serial_out_line);
endinterface
`default_nettype wire

// file: logic/srap_device.sv
`timescale 1ns/1ns
`default_nettype none
module srap_device (
  input wire logic sys_clk,
  input wire logic rst,
  srap_link_if.device link,
  input wire logic [1:0] strap_mode,
  input wire logic soft_pd,
  input wire logic [7:0] reg_rdata,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  output logic restore_defaults,
  output logic [1:0] port_mode
);
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TACK} srap_i2c_st_t;

  function automatic logic [15:0] inc16(input logic [15:0] a);
    inc16 = a + 16'h0001;
  endfunction

  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic scl_s;
  logic sel_s;
  logic sdi_s;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic [1:0] mode_q, mode_d;
  logic cap_q, cap_d;
  logic dflt_q, dflt_d;
  logic [5:0] cnt_q, cnt_d;
  logic [26:0] sh_q, sh_d;
  logic [2:0] cmd_q, cmd_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] raddr_q, raddr_d;
  logic [7:0] wdat_q, wdat_d;
  logic we_q, we_d;
  logic re_q, re_d;
  logic ld_q, ld_d;
  logic [7:0] obuf_q, obuf_d;
  logic out_q, out_d;
  logic out_oe_n_q, out_oe_n_d;
  logic in_oe_n_q, in_oe_n_d;
  srap_i2c_st_t ist_q, ist_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [1:0] ph_q, ph_d;
  logic rw_q, rw_d;

  // pins are unrelated to sys_clk; the third stage only feeds edge finding
  always_ff @(posedge sys_clk) begin
    s1_q <= {soft_pd, strap_mode, link.serial_in_line,
             link.serial_select_low, link.serial_clk};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  assign scl_s = s2_q[0];
  assign sel_s = s2_q[1];
  assign sdi_s = s2_q[2];
  assign scl_rise = scl_s & ~s3_q[0];
  assign scl_fall = ~scl_s & s3_q[0];
  assign i2c_start = scl_s & s3_q[0] & ~sdi_s & s3_q[2];
  assign i2c_stop = scl_s & s3_q[0] & sdi_s & ~s3_q[2];

  always_comb begin
    mode_d = mode_q;
    cap_d = 1'b0;
    dflt_d = 1'b0;
    cnt_d = cnt_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    raddr_d = raddr_q;
    wdat_d = wdat_q;
    we_d = 1'b0;
    re_d = 1'b0;
    obuf_d = obuf_q;
    out_d = out_q;
    out_oe_n_d = out_oe_n_q;
    in_oe_n_d = in_oe_n_q;
    ist_d = ist_q;
    bcnt_d = bcnt_q;
    ph_d = ph_q;
    rw_d = rw_q;
    // read data arrives the cycle after the strobe, so capture it then
    ld_d = re_q;
    if (ld_q) begin
      obuf_d = reg_rdata;
    end
    // soft power-down does not stop the port; only its release re-straps the mode and restores defaults
    if (cap_q) begin
      mode_d = s2_q[4:3];
      cnt_d = 6'h00;
      cmd_d = 3'h0;
      ist_d = I_IDLE;
      in_oe_n_d = 1'b1;
      out_oe_n_d = 1'b1;
    end else if (!s2_q[5] && s3_q[5]) begin
      cap_d = 1'b1;
      dflt_d = 1'b1;
    end else if (mode_q == srap_pkg::MODE_SPI) begin
      if (sel_s) begin
        cnt_d = 6'h00;
        cmd_d = 3'h0;
        out_oe_n_d = 1'b1;
      end else if (scl_rise) begin
        sh_d = {sh_q[25:0], sdi_s};
        cnt_d = (cnt_q == srap_pkg::SPI_DATA_LAST) ?
                srap_pkg::SPI_DATA_FIRST : cnt_q + 6'h01;
        if (cnt_q == srap_pkg::SPI_CA_LAST) begin
          cmd_d = sh_d[26:24];
          addr_d = sh_d[15:0];
          if (sh_d[26:24] == srap_pkg::SPI_CMD_READ) begin
            re_d = 1'b1;
            raddr_d = sh_d[15:0];
          end
        end
        // the data byte is the last eight samples; turnaround bits drop out
        if (cnt_q == srap_pkg::SPI_DATA_LAST) begin
          addr_d = inc16(addr_q);
          if (cmd_q == srap_pkg::SPI_CMD_READ) begin
            re_d = 1'b1;
            raddr_d = addr_d;
          end else if (cmd_q == srap_pkg::SPI_CMD_WRITE) begin
            we_d = 1'b1;
            raddr_d = addr_q;
            wdat_d = sh_d[7:0];
          end
        end
      end else if (scl_fall && cmd_q == srap_pkg::SPI_CMD_READ &&
                   cnt_q >= srap_pkg::SPI_DATA_FIRST) begin
        out_d = obuf_q[3'(srap_pkg::SPI_DATA_LAST - cnt_q)];
        out_oe_n_d = 1'b0;
      end
    end else if (mode_q == srap_pkg::MODE_I2C) begin
      out_oe_n_d = 1'b1;
      if (i2c_start) begin
        ist_d = I_RX;
        bcnt_d = 4'h0;
        ph_d = 2'h0;
        in_oe_n_d = 1'b1;
      end else if (i2c_stop) begin
        ist_d = I_IDLE;
        in_oe_n_d = 1'b1;
      end else begin
        case (ist_q)
          I_RX: begin
            if (scl_rise) begin
              sh_d = {sh_q[25:0], sdi_s};
              bcnt_d = bcnt_q + 4'h1;
            end else if (scl_fall && bcnt_q == srap_pkg::I2C_ACK_BIT) begin
              ist_d = I_ACK;
              in_oe_n_d = 1'b0;
              ph_d = (ph_q == 2'h3) ? ph_q : ph_q + 2'h1;
              case (ph_q)
                2'h0: begin
                  if (sh_q[7:1] == srap_pkg::I2C_DEV_ADDR) begin
                    rw_d = sh_q[0];
                    re_d = sh_q[0];
                    raddr_d = addr_q;
                  end else begin
                    ist_d = I_IDLE;
                    in_oe_n_d = 1'b1;
                  end
                end
                2'h1: addr_d[15:8] = sh_q[7:0];
                2'h2: addr_d[7:0] = sh_q[7:0];
                default: begin
                  we_d = 1'b1;
                  raddr_d = addr_q;
                  wdat_d = sh_q[7:0];
                  addr_d = inc16(addr_q);
                end
              endcase
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              bcnt_d = 4'h0;
              if (rw_q) begin
                ist_d = I_TX;
                in_oe_n_d = obuf_q[7];
              end else begin
                ist_d = I_RX;
                in_oe_n_d = 1'b1;
              end
            end
          end
          I_TX: begin
            if (scl_rise) begin
              bcnt_d = bcnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bcnt_q == srap_pkg::I2C_ACK_BIT) begin
                ist_d = I_TACK;
                in_oe_n_d = 1'b1;
              end else begin
                in_oe_n_d = obuf_q[3'(4'h7 - bcnt_q)];
              end
            end
          end
          I_TACK: begin
            if (scl_rise) begin
              if (!sdi_s) begin
                ist_d = I_ACK;
                addr_d = inc16(addr_q);
                re_d = 1'b1;
                raddr_d = addr_d;
              end else begin
                ist_d = I_IDLE;
              end
            end
          end
          default: ist_d = I_IDLE;
        endcase
      end
    end
    // MIIM frames are served by the PHY side; this port stays quiet
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= srap_pkg::MODE_SPI;
      cap_q <= 1'b1;
      dflt_q <= 1'b0;
      cnt_q <= 6'h00;
      sh_q <= 27'h0000000;
      cmd_q <= 3'h0;
      addr_q <= 16'h0000;
      raddr_q <= 16'h0000;
      wdat_q <= 8'h00;
      we_q <= 1'b0;
      re_q <= 1'b0;
      ld_q <= 1'b0;
      obuf_q <= 8'h00;
      out_q <= 1'b0;
      out_oe_n_q <= 1'b1;
      in_oe_n_q <= 1'b1;
      ist_q <= I_IDLE;
      bcnt_q <= 4'h0;
      ph_q <= 2'h0;
      rw_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cap_q <= cap_d;
      dflt_q <= dflt_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      raddr_q <= raddr_d;
      wdat_q <= wdat_d;
      we_q <= we_d;
      re_q <= re_d;
      ld_q <= ld_d;
      obuf_q <= obuf_d;
      out_q <= out_d;
      out_oe_n_q <= out_oe_n_d;
      in_oe_n_q <= in_oe_n_d;
      ist_q <= ist_d;
      bcnt_q <= bcnt_d;
      ph_q <= ph_d;
      rw_q <= rw_d;
    end
  end

  assign link.dev_in_o = 1'b0;
  assign link.dev_in_oe_n = in_oe_n_q;
  assign link.dev_out_o = out_q;
  assign link.dev_out_oe_n = out_oe_n_q;
  assign reg_addr = raddr_q;
  assign reg_wdata = wdat_q;
  assign reg_we = we_q;
  assign reg_re = re_q;
  assign restore_defaults = dflt_q;
  assign port_mode = mode_q;
endmodule
`default_nettype wire

// file: logic/srap_host.sv
`timescale 1ns/1ns
`default_nettype none
module srap_host #(
  parameter int HALF = srap_pkg::SCLK_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  srap_link_if.host link,
  input wire logic cmd_start,
  input wire logic cmd_i2c,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_wdata,
  output logic busy,
  output logic byte_done,
  output logic [7:0] rdata,
  output logic nack
);
  typedef enum logic [2:0] {
    H_IDLE, H_SPI, H_END, H_START, H_BYTE, H_STOP
  } srap_host_st_t;
  localparam logic [2:0] B_RD_ADDR = 3'h4;
  localparam logic [2:0] B_RD_DATA = 3'h5;

  function automatic logic [7:0] tx_byte(input logic [2:0] b,
                                         input logic [15:0] a,
                                         input logic [7:0] w);
    case (b)
      3'h0: tx_byte = {srap_pkg::I2C_DEV_ADDR, 1'b0};
      3'h1: tx_byte = a[15:8];
      3'h2: tx_byte = a[7:0];
      B_RD_ADDR: tx_byte = {srap_pkg::I2C_DEV_ADDR, 1'b1};
      B_RD_DATA: tx_byte = 8'hFF;
      default: tx_byte = w;
    endcase
  endfunction

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic tick;
  logic [7:0] tb;
  srap_host_st_t st_q, st_d;
  logic [7:0] div_q, div_d;
  logic scl_q, scl_d;
  logic sel_n_q, sel_n_d;
  logic pin_o_q, pin_o_d;
  logic pin_oe_n_q, pin_oe_n_d;
  logic [5:0] cnt_q, cnt_d;
  logic [39:0] sh_q, sh_d;
  logic [7:0] left_q, left_d;
  logic [2:0] bidx_q, bidx_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] stp_q, stp_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] wbuf_q, wbuf_d;
  logic [15:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;
  logic nack_q, nack_d;

  always_ff @(posedge sys_clk) begin
    s1_q <= {link.serial_out_line, link.serial_in_line};
    s2_q <= s1_q;
  end

  assign tick = (div_q == 8'(HALF - 1));

  always_comb begin
    st_d = st_q;
    div_d = (st_q == H_IDLE || tick) ? 8'h00 : div_q + 8'h01;
    scl_d = scl_q;
    sel_n_d = sel_n_q;
    pin_o_d = pin_o_q;
    pin_oe_n_d = pin_oe_n_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    left_d = left_q;
    bidx_d = bidx_q;
    bit_d = bit_q;
    stp_d = stp_q;
    rx_d = rx_q;
    wbuf_d = wbuf_q;
    addr_d = addr_q;
    rd_d = rd_q;
    busy_d = busy_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    nack_d = nack_q;
    tb = tx_byte(bidx_q, addr_q, wbuf_q);
    case (st_q)
      H_IDLE: begin
        if (cmd_start) begin
          busy_d = 1'b1;
          nack_d = 1'b0;
          rd_d = cmd_read;
          addr_d = cmd_addr;
          wbuf_d = cmd_wdata;
          left_d = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
          if (cmd_i2c) begin
            st_d = H_START;
            stp_d = 2'h0;
            bidx_d = 3'h0;
            pin_o_d = 1'b0;
          end else begin
            st_d = H_SPI;
            sel_n_d = 1'b0;
            sh_d = {cmd_read ? srap_pkg::SPI_CMD_READ :
                    srap_pkg::SPI_CMD_WRITE, 8'h00, cmd_addr,
                    5'h00, cmd_wdata};
            pin_o_d = sh_d[39];
            pin_oe_n_d = 1'b0;
            cnt_d = 6'h00;
          end
        end
      end
      H_SPI: begin
        if (tick) begin
          if (!scl_q) begin
            scl_d = 1'b1;
          end else begin
            scl_d = 1'b0;
            rx_d = {rx_q[6:0], s2_q[1]};
            sh_d = {sh_q[38:0], 1'b0};
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == srap_pkg::SPI_DATA_LAST) begin
              cnt_d = srap_pkg::SPI_DATA_FIRST;
              done_d = 1'b1;
              rdata_d = rx_d;
              left_d = left_q - 8'h01;
              if (left_q == 8'h01) begin
                st_d = H_END;
              end else begin
                sh_d[39:32] = cmd_wdata;
              end
            end
            pin_o_d = sh_d[39];
          end
        end
      end
      H_END: begin
        if (tick) begin
          sel_n_d = 1'b1;
          pin_oe_n_d = 1'b1;
          busy_d = 1'b0;
          st_d = H_IDLE;
        end
      end
      H_START: begin
        if (tick) begin
          stp_d = stp_q + 2'h1;
          case (stp_q)
            2'h0: pin_oe_n_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: pin_oe_n_d = 1'b0;
            default: begin
              scl_d = 1'b0;
              st_d = H_BYTE;
              bit_d = 4'h0;
              pin_oe_n_d = (bidx_q == B_RD_DATA) | tb[7];
            end
          endcase
        end
      end
      H_BYTE: begin
        if (tick) begin
          if (!scl_q) begin
            scl_d = 1'b1;
          end else begin
            scl_d = 1'b0;
            bit_d = bit_q + 4'h1;
            if (bit_q < 4'h7) begin
              rx_d = {rx_q[6:0], s2_q[0]};
              pin_oe_n_d = (bidx_q == B_RD_DATA) | tb[3'(4'h6 - bit_q)];
            end else if (bit_q == 4'h7) begin
              rx_d = {rx_q[6:0], s2_q[0]};
              // last read byte is not acknowledged
              pin_oe_n_d = (bidx_q != B_RD_DATA) | (left_q == 8'h01);
            end else begin
              pin_oe_n_d = 1'b1;
              bit_d = 4'h0;
              if (bidx_q != B_RD_DATA && s2_q[0]) begin
                nack_d = 1'b1;
                st_d = H_STOP;
                stp_d = 2'h0;
              end else begin
                case (bidx_q)
                  3'h2: begin
                    if (rd_q) begin
                      st_d = H_START;
                      stp_d = 2'h0;
                      bidx_d = B_RD_ADDR;
                    end else begin
                      bidx_d = 3'h3;
                    end
                  end
                  3'h3, B_RD_DATA: begin
                    done_d = 1'b1;
                    rdata_d = rx_q;
                    wbuf_d = cmd_wdata;
                    left_d = left_q - 8'h01;
                    if (left_q == 8'h01) begin
                      st_d = H_STOP;
                      stp_d = 2'h0;
                    end
                  end
                  default: bidx_d = bidx_q + 3'h1;
                endcase
                if (st_d == H_BYTE) begin
                  pin_oe_n_d = (bidx_d == B_RD_DATA) |
                               tx_byte(bidx_d, addr_q, wbuf_d) == 8'hFF ?
                               1'b1 : tx_byte(bidx_d, addr_q, wbuf_d) >= 8'h80;
                end
              end
            end
          end
        end
      end
      H_STOP: begin
        if (tick) begin
          stp_d = stp_q + 2'h1;
          case (stp_q)
            2'h0: pin_oe_n_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: pin_oe_n_d = 1'b1;
            default: begin
              scl_d = 1'b0;
              busy_d = 1'b0;
              st_d = H_IDLE;
            end
          endcase
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= H_IDLE;
      div_q <= 8'h00;
      scl_q <= 1'b0;
      sel_n_q <= 1'b1;
      pin_o_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
      cnt_q <= 6'h00;
      sh_q <= 40'h0000000000;
      left_q <= 8'h00;
      bidx_q <= 3'h0;
      bit_q <= 4'h0;
      stp_q <= 2'h0;
      rx_q <= 8'h00;
      wbuf_q <= 8'h00;
      addr_q <= 16'h0000;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      nack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      scl_q <= scl_d;
      sel_n_q <= sel_n_d;
      pin_o_q <= pin_o_d;
      pin_oe_n_q <= pin_oe_n_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      left_q <= left_d;
      bidx_q <= bidx_d;
      bit_q <= bit_d;
      stp_q <= stp_d;
      rx_q <= rx_d;
      wbuf_q <= wbuf_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      busy_q <= busy_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      nack_q <= nack_d;
    end
  end

  assign link.serial_clk = scl_q;
  assign link.serial_select_low = sel_n_q;
  assign link.host_in_o = pin_o_q;
  assign link.host_in_oe_n = pin_oe_n_q;
  assign busy = busy_q;
  assign byte_done = done_q;
  assign rdata = rdata_q;
  assign nack = nack_q;
endmodule
`default_nettype wire

// file: test/srap_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module srap_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_select_low,
  input wire logic host_in_o,
  input wire logic dev_in_oe_n,
  input wire logic dev_out_o,
  input wire logic dev_out_oe_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_idle_float;
    serial_select_low [*5] |-> dev_out_oe_n;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("output driven while deselected");
  property p_release;
    $rose(serial_select_low) |-> ##[0:4] dev_out_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released after deselect");
  property p_ca_float;
    $fell(serial_select_low) |-> dev_out_oe_n [*8];
  endproperty
  a_ca_float: assert property (p_ca_float)
    else $error("output driven in command phase");
  property p_no_in_pull;
    !serial_select_low |-> dev_in_oe_n;
  endproperty
  a_no_in_pull: assert property (p_no_in_pull)
    else $error("device drives input line in spi");
  property p_clk_low_sel;
    $changed(serial_select_low) |-> !serial_clk;
  endproperty
  a_clk_low_sel: assert property (p_clk_low_sel)
    else $error("serial clock high at select edge");
  property p_half;
    $rose(serial_clk) && !serial_select_low |=> serial_clk [*3];
  endproperty
  a_half: assert property (p_half)
    else $error("serial clock high phase too short");
  property p_in_stable;
    $rose(serial_clk) && !serial_select_low |-> $stable(host_in_o);
  endproperty
  a_in_stable: assert property (p_in_stable)
    else $error("input data moved at rising edge");
  property p_out_stable;
    $rose(serial_clk) && !serial_select_low |=> $stable(dev_out_o) [*2];
  endproperty
  a_out_stable: assert property (p_out_stable)
    else $error("output moved after rising edge");
endmodule
`default_nettype wire

// file: test/srap_tb.sv
`timescale 1ns/1ns
`default_nettype none
module srap_tb;
  logic sys_clk = 0;
  logic rst = 1;
  logic [1:0] strap_mode = 2'h0;
  logic soft_pd = 0;
  logic [7:0] reg_rdata = 8'h00;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we, reg_re, restore_defaults;
  logic [1:0] port_mode;
  logic cmd_start = 0, cmd_i2c = 0, cmd_read = 0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h00, cmd_wdata = 8'h00;
  logic busy, byte_done, nack;
  logic [7:0] rdata;
  logic [7:0] mem [logic [15:0]];
  logic [7:0] got [$];
  logic [7:0] e [4] = '{8'h11, 8'h22, 8'h33, 8'hFD};
  int bad_count = 0, n_tests = 0, cyc = 0, n_rst = 0;
  srap_link_if link ();
  srap_device srap_device_i (.sys_clk(sys_clk), .rst(rst), .link(link),
    .strap_mode(strap_mode), .soft_pd(soft_pd), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .restore_defaults(restore_defaults),
    .port_mode(port_mode));
  srap_host srap_host_i (.sys_clk(sys_clk), .rst(rst), .link(link),
    .cmd_start(cmd_start), .cmd_i2c(cmd_i2c), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata),
    .busy(busy), .byte_done(byte_done), .rdata(rdata), .nack(nack));
  srap_monitor srap_monitor_i (.sys_clk(sys_clk), .rst(rst),
    .serial_clk(link.serial_clk), .serial_select_low(link.serial_select_low),
    .host_in_o(link.host_in_o), .dev_in_oe_n(link.dev_in_oe_n),
    .dev_out_o(link.dev_out_o), .dev_out_oe_n(link.dev_out_oe_n));
  initial forever #50 sys_clk = ~sys_clk;
  // register file; unwritten bytes read as the inverted low address
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (reg_we)
      mem[reg_addr] = reg_wdata;
    if (reg_re)
      reg_rdata <= mem.exists(reg_addr) ? mem[reg_addr] : ~reg_addr[7:0];
    if (restore_defaults) begin
      n_rst++;
      mem.delete();
    end
    if (cyc == 30000) begin
      $display("[ERR] %0t run timed out", $time);
      bad_count++;
      test_done();
    end
  end
  task automatic chk_data(input logic [15:0] g, input logic [15:0] x);
    n_tests++;
    if (g !== x)
      bad_count++;
    if (g !== x)
      $display("[ERR] %0t got %h expected %h", $time, g, x);
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge sys_clk);
    rst <= 1'b1;
    strap_mode <= m;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_data(16'(port_mode), 16'(m));
  endtask
  // w holds the bytes to write, or one dummy per byte to read
  task automatic xfer(input logic i2c, input logic rd,
                      input logic [15:0] a, input logic [7:0] w [$]);
    int k;
    got.delete();
    @(posedge sys_clk);
    cmd_start <= 1'b1;
    cmd_i2c <= i2c;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_len <= 8'(w.size());
    cmd_wdata <= w[0];
    w.push_back(8'h00);
    w.push_back(8'h00);
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    cmd_wdata <= w[1];
    for (k = 0; k < 4000 && (busy !== 1'b0 || k < 2); k++) begin
      @(posedge sys_clk);
      if (byte_done === 1'b1) begin
        got.push_back(rdata);
        cmd_wdata <= w[got.size() + 1];
      end
    end
    if (k == 4000)
      chk_data(16'h0000, 16'h0001);
    chk_data(16'(nack), 16'h0000);
  endtask
  initial begin
    do_reset(2'h0);
    strap_mode <= 2'h1;
    repeat (5) @(posedge sys_clk);
    chk_data(16'(port_mode), 16'h0000);
    xfer(1'b0, 1'b0, 16'h1234, '{8'hA5});
    chk_data(16'(mem[16'h1234]), 16'h00A5);
    xfer(1'b0, 1'b1, 16'h1234, '{8'h00});
    chk_data(16'(got[0]), 16'h00A5);
    repeat (4) @(posedge sys_clk);
    chk_data(16'({link.serial_clk, link.dev_out_oe_n}), 16'h0001);
    $display("test spi single done");
    xfer(1'b0, 1'b0, 16'h00FF, '{8'h11, 8'h22, 8'h33});
    xfer(1'b0, 1'b1, 16'h00FF, '{8'h00, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 4; i++)
      chk_data(16'(got[i]), 16'(e[i]));
    $display("test spi burst done");
    do_reset(2'h1);
    xfer(1'b1, 1'b0, 16'hBEEF, '{8'h5A, 8'hC3});
    xfer(1'b1, 1'b1, 16'hBEEF, '{8'h00, 8'h00});
    chk_data(16'({got[0], got[1]}), 16'h5AC3);
    $display("test i2c done");
    soft_pd <= 1'b1;
    xfer(1'b1, 1'b0, 16'h0042, '{8'h77});
    chk_data(16'(mem[16'h0042]), 16'h0077);
    strap_mode <= 2'h0;
    repeat (5) @(posedge sys_clk);
    soft_pd <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_data(16'(n_rst), 16'h0001);
    chk_data(16'(port_mode), 16'h0000);
    xfer(1'b0, 1'b1, 16'h0042, '{8'h00});
    chk_data(16'(got[0]), 16'h00BD);
    $display("test power down done");
    do_reset(2'h2);
    xfer(1'b0, 1'b0, 16'h0050, '{8'h99});
    chk_data(16'(mem.exists(16'h0050)), 16'h0000);
    $display("test miim done");
    test_done();
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
